// ### include/rps_consts.vh
// constants for the reset and power supervisor
`ifndef RPS_CONSTS_VH
`define RPS_CONSTS_VH
`define RPS_CAUSE_W        6
`define RPS_CAUSE_PIN      0
`define RPS_CAUSE_POWERON  1
`define RPS_CAUSE_BROWNOUT 2
`define RPS_CAUSE_WDOG     3
`define RPS_CAUSE_SOFT     4
`define RPS_CAUSE_BREAK    5
`define RPS_CAUSE_RST      6'h00
`define RPS_CAUSE_PORSET   6'h06
`define RPS_MODE_RUN       2'h0
`define RPS_MODE_IDLE      2'h1
`define RPS_MODE_PD        2'h2
`define RPS_MODE_TPD       2'h3
`define RPS_ZERO_VECTOR    16'h0000
`define RPS_VEC_LOW        8'h00
`define RPS_REL_STAGES     2
`endif

// ### logic/rps_release_sync.v
// reset release synchroniser: asserts at once, releases after two clocks
`timescale 1ns/100ps
module rps_release_sync (
    input  wire ref_clk_i,
    input  wire reset_n_i,
    input  wire ce_i,
    input  wire req_i,
    output wire rst_n_o
);
    reg [1:0] stage;
    // request forces reset asynchronously, release shifts through two flops
    wire clr_n = reset_n_i & ~req_i;
    always @(posedge ref_clk_i or negedge clr_n) begin
        if (!clr_n) begin
            stage <= 2'h0;
        end else if (ce_i) begin
            stage <= {stage[0], 1'b1};
        end
    end
    assign rst_n_o = stage[1];
endmodule // rps_release_sync

// ### logic/rps_supervisor.v
// reset and power supervisor: brownout, reset causes, modes and fetch vector
`timescale 1ns/100ps
`include "rps_consts.vh"
module rps_supervisor (
    input  wire        ref_clk_i,
    input  wire        reset_n_i,          // power-on detect, active low
    input  wire        ce_i,
    input  wire [1:0]  supply_level_i,     // quantised supply: 0 lowest .. 3 highest step
    input  wire        supply_flash_ok_i,  // supply above fixed flash trip level
    input  wire        brownout_reset_trip_hi_i,
    input  wire        brownout_reset_trip_lo_i,
    input  wire        brownout_irq_trip_hi_i,
    input  wire        brownout_irq_trip_lo_i,
    input  wire        brownout_irq_en_i,
    input  wire        reset_pin_select_i,
    input  wire        shared_reset_pin_i,
    input  wire        wdog_reset_i,
    input  wire        soft_reset_i,
    input  wire        break_reset_i,
    input  wire        idle_req_i,
    input  wire        pd_req_i,
    input  wire        tpd_req_i,
    input  wire        irq_pending_i,      // any enabled interrupt
    input  wire        wake_irq_i,         // interrupt able to wake power-down
    input  wire        rc_is_sysclk_i,
    input  wire        rtc_en_i,
    input  wire        comp_pd_i,          // comparators powered down separately
    input  wire        cause_wr_i,
    input  wire [5:0]  cause_wdata_i,
    input  wire        boot_status0_i,
    input  wire        isp_force_i,
    input  wire [7:0]  boot_vector_i,
    output reg  [5:0]  reset_cause_register_o,
    output reg         sys_reset_n_o,
    output reg         brownout_irq_o,
    output reg         flash_lockout_o,
    output reg         pin_data_o,
    output reg  [1:0]  mode_o,
    output reg         main_osc_en_o,
    output reg         rc_osc_en_o,
    output reg         periph_clk_en_o,
    output reg         keep_alive_en_o,    // watchdog and timer in power-down
    output reg         comp_en_o,
    output reg         bod_en_o,
    output reg  [15:0] fetch_addr_o
);
    reg        powering_up;
    reg [1:0]  mode;
    reg        bod_reset_cond;
    reg        pin_reset;
    reg        boot_use;
    reg [5:0]  next_cause;
    reg [1:0]  next_mode;
    reg        next_boot_use;
    reg        next_brownout_irq;
    reg        next_flash_lockout;
    reg        next_pin_data;
    reg        next_main_osc_en;
    reg        next_rc_osc_en;
    reg        next_comp_en;
    reg [15:0] next_fetch_addr;
    wire       in_power_down;                     // power-down or total power-down
    wire       bod_irq_cond;
    wire       boot_force;
    wire [1:0] rst_sel = {brownout_reset_trip_hi_i, brownout_reset_trip_lo_i};
    wire [1:0] irq_sel = {brownout_irq_trip_hi_i, brownout_irq_trip_lo_i};
    wire       bod_on  = (mode != `RPS_MODE_TPD);
    wire       internal_req;
    wire       core_rst_n;

    // mode decode shared by the clock enables and the flash lockout
    assign in_power_down = (mode == `RPS_MODE_PD) || (mode == `RPS_MODE_TPD);
    // brownout interrupt level compare, gated by the software enable
    assign bod_irq_cond = brownout_irq_en_i && bod_on && (supply_level_i <= irq_sel);
    // boot page is latched on break or on forced programming during power-up, so it outlasts the window
    assign boot_force = break_reset_i || (isp_force_i && powering_up);

    // brownout reset: supply at or below selected level, gated only by total power-down mode
    always @* begin
        bod_reset_cond = bod_on && (supply_level_i <= rst_sel);
    end

    // pin acts as reset during power-up or when selected
    always @* begin
        pin_reset = !shared_reset_pin_i && (powering_up || reset_pin_select_i);
    end

    assign internal_req = bod_reset_cond | pin_reset | wdog_reset_i | soft_reset_i | break_reset_i;

    rps_release_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .req_i     (internal_req),
        .rst_n_o   (core_rst_n)
    );

    // power-up window lasts until the first release of the core reset
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            powering_up <= 1'b1;
        end else if (ce_i && core_rst_n) begin
            powering_up <= 1'b0;
        end
    end

    // cause flags: set beats software clear
    always @* begin
        next_cause = reset_cause_register_o;
        if (cause_wr_i) begin
            next_cause = next_cause & cause_wdata_i;
        end
        if (wdog_reset_i) begin
            next_cause = `RPS_CAUSE_PORSET;
        end else begin
            if (pin_reset) begin
                next_cause[`RPS_CAUSE_PIN] = 1'b1;
            end
            if (bod_reset_cond) begin
                next_cause[`RPS_CAUSE_BROWNOUT] = 1'b1;
            end
            if (soft_reset_i) begin
                next_cause[`RPS_CAUSE_SOFT] = 1'b1;
            end
            if (break_reset_i) begin
                next_cause[`RPS_CAUSE_BREAK] = 1'b1;
            end
        end
    end

    // boot flag: set on break or forced programming, kept across brownout resets
    always @* begin
        next_boot_use = boot_use;
        if (boot_force) begin
            next_boot_use = 1'b1;
        end else if (internal_req && !bod_reset_cond) begin
            next_boot_use = 1'b0;
        end
    end

    // flags update while reset is held, before the release leaves the synchroniser
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reset_cause_register_o <= `RPS_CAUSE_RST;
            boot_use               <= 1'b0;
        end else if (ce_i) begin
            if (powering_up && !core_rst_n && !reset_cause_register_o[`RPS_CAUSE_POWERON]) begin
                reset_cause_register_o <= `RPS_CAUSE_PORSET;
            end else begin
                reset_cause_register_o <= next_cause;
            end
            boot_use <= next_boot_use;
        end
    end

    // power mode machine: any reset returns to run, requests only taken in run
    always @* begin
        next_mode = mode;
        if (!core_rst_n) begin
            next_mode = `RPS_MODE_RUN;
        end else begin
            case (mode)
                `RPS_MODE_RUN: begin
                    if (tpd_req_i) begin
                        next_mode = `RPS_MODE_TPD;
                    end else if (pd_req_i) begin
                        next_mode = `RPS_MODE_PD;
                    end else if (idle_req_i) begin
                        next_mode = `RPS_MODE_IDLE;
                    end
                end
                `RPS_MODE_IDLE: begin
                    if (irq_pending_i) begin
                        next_mode = `RPS_MODE_RUN;
                    end
                end
                `RPS_MODE_PD,
                `RPS_MODE_TPD: begin
                    if (wake_irq_i) begin
                        next_mode = `RPS_MODE_RUN;
                    end
                end
                default: begin
                    next_mode = `RPS_MODE_RUN;
                end
            endcase
        end
    end

    // mode register, frozen while the clock enable is low
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode <= `RPS_MODE_RUN;
        end else if (ce_i) begin
            mode <= next_mode;
        end
    end

    // next values of the supply watch, clock and pin outputs
    always @* begin
        next_brownout_irq  = bod_irq_cond;
        next_flash_lockout = in_power_down ? 1'b0 : !supply_flash_ok_i;
        next_pin_data      = (reset_pin_select_i || powering_up) ? 1'b1 : shared_reset_pin_i;
        next_main_osc_en   = !in_power_down;
        next_rc_osc_en     = !in_power_down || (rc_is_sysclk_i && rtc_en_i);
        next_comp_en       = bod_on && !comp_pd_i;
    end

    // fetch vector: boot page or zero
    always @* begin
        if (boot_use || boot_status0_i) begin
            next_fetch_addr = {boot_vector_i, `RPS_VEC_LOW};
        end else begin
            next_fetch_addr = `RPS_ZERO_VECTOR;
        end
    end

    // reset release, pin data and fetch vector outputs
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sys_reset_n_o   <= 1'b0;
            pin_data_o      <= 1'b1;
            fetch_addr_o    <= `RPS_ZERO_VECTOR;
        end else if (ce_i) begin
            sys_reset_n_o   <= core_rst_n;
            pin_data_o      <= next_pin_data;
            fetch_addr_o    <= next_fetch_addr;
        end
    end

    // supply watch outputs: brownout interrupt, flash lockout and detector enables
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            brownout_irq_o  <= 1'b0;
            flash_lockout_o <= 1'b1;
            comp_en_o       <= 1'b1;
            bod_en_o        <= 1'b1;
        end else if (ce_i) begin
            brownout_irq_o  <= next_brownout_irq;
            flash_lockout_o <= next_flash_lockout;
            comp_en_o       <= next_comp_en;
            bod_en_o        <= bod_on;
        end
    end

    // mode, oscillator and peripheral clock enables follow the mode register one cycle late; keep-alive stays on
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_o          <= `RPS_MODE_RUN;
            main_osc_en_o   <= 1'b1;
            rc_osc_en_o     <= 1'b1;
            periph_clk_en_o <= 1'b1;
            keep_alive_en_o <= 1'b1;
        end else if (ce_i) begin
            mode_o          <= mode;
            main_osc_en_o   <= next_main_osc_en;
            rc_osc_en_o     <= next_rc_osc_en;
            periph_clk_en_o <= next_main_osc_en;
            keep_alive_en_o <= 1'b1;
        end
    end
endmodule // rps_supervisor

// ### tb/rps_supervisor_asserts.sv
// assertion checker for the reset and power supervisor
`timescale 1ns/100ps
module rps_supervisor_asserts (
    input wire        ref_clk_i,
    input wire        reset_n_i,
    input wire        wdog_reset_i,
    input wire        soft_reset_i,
    input wire        break_reset_i,
    input wire        reset_pin_select_i,
    input wire        shared_reset_pin_i,
    input wire        irq_pending_i,
    input wire        cause_wr_i,
    input wire [5:0]  cause_wdata_i,
    input wire [1:0]  supply_level_i,
    input wire        brownout_reset_trip_hi_i,
    input wire        brownout_reset_trip_lo_i,
    input wire [5:0]  reset_cause_register_o,
    input wire        sys_reset_n_o,
    input wire [1:0]  mode_o,
    input wire        main_osc_en_o,
    input wire        comp_en_o,
    input wire        bod_en_o,
    input wire [15:0] fetch_addr_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // reset requests, flags and clears
    a_req_reset: assert property ((soft_reset_i || wdog_reset_i || break_reset_i) |=> !sys_reset_n_o)
        else $error("reset not asserted");
    a_pin_reset: assert property (reset_pin_select_i && !shared_reset_pin_i |=> !sys_reset_n_o)
        else $error("pin reset ignored");
    a_soft_flag: assert property (soft_reset_i && !wdog_reset_i |=> reset_cause_register_o[4])
        else $error("soft flag not set");
    a_wdog_flags: assert property (wdog_reset_i |=> reset_cause_register_o == 6'h06)
        else $error("watchdog flags wrong");
    a_clear_flag: assert property (
        cause_wr_i && sys_reset_n_o && !(soft_reset_i || wdog_reset_i || break_reset_i)
        && !(reset_pin_select_i && !shared_reset_pin_i)
        && !(supply_level_i <= {brownout_reset_trip_hi_i, brownout_reset_trip_lo_i})
        |=> reset_cause_register_o == ($past(reset_cause_register_o) & $past(cause_wdata_i)))
        else $error("flag clear wrong");
    // modes and fetch vector
    a_pd_osc: assert property (mode_o[1] |-> !main_osc_en_o)
        else $error("oscillator runs in power-down");
    a_tpd_off: assert property (mode_o == 2'h3 |-> !bod_en_o && !comp_en_o)
        else $error("detector on in total power-down");
    a_idle_exit: assert property (mode_o == 2'h1 && irq_pending_i |-> ##[1:3] mode_o == 2'h0)
        else $error("idle not left");
    a_vec_low: assert property (fetch_addr_o[7:0] == 8'h00)
        else $error("fetch low byte not zero");
    c_pd: cover property (mode_o == 2'h2);
    c_tpd: cover property (mode_o == 2'h3);
    c_release: cover property ($rose(sys_reset_n_o));
endmodule // rps_supervisor_asserts

// ### tb/rps_pin_model.sv
// far-side model: external circuit on the shared reset pin
`timescale 1ns/100ps
module rps_pin_model (
    input  wire  hold_low_i,
    output logic pin_o
);
    // released pin floats to its pull-up level
    assign pin_o = hold_low_i ? 1'b0 : 1'b1;
endmodule // rps_pin_model

// ### tb/testbench.sv
// self-checking bench for the reset and power supervisor
`timescale 1ns/100ps
module testbench;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  sup = 2'h3, bt = 2'h0, it = 2'h1;
    logic        ien = 1'b1, bs = 1'b0, sel = 1'b0, hold = 1'b0, cw = 1'b0, irq = 1'b0, wk = 1'b0, rtc = 1'b0;
    logic        ce = 1'b1, fok = 1'b1, cpd = 1'b0, rcs = 1'b1, isp = 1'b0;
    logic [2:0]  rq = 3'h0, md = 3'h0;
    logic [5:0]  wd = 6'h00;
    logic [7:0]  vec = 8'hA5;
    wire  [5:0]  cause;
    wire  [1:0]  mode;
    wire  [15:0] fa;
    wire         srn, birq, mosc, rosc, pclk, kal, cen, ben, pin, flk, pdat;
    int          errors = 0, checks_done = 0;
    always #2.5 ref_clk = ~ref_clk;
    rps_pin_model far (.hold_low_i(hold), .pin_o(pin));
    rps_supervisor uut (.ref_clk_i(ref_clk), .reset_n_i(rst_n), .ce_i(ce), .supply_level_i(sup),
        .supply_flash_ok_i(fok), .brownout_reset_trip_hi_i(bt[1]), .brownout_reset_trip_lo_i(bt[0]),
        .brownout_irq_trip_hi_i(it[1]), .brownout_irq_trip_lo_i(it[0]), .brownout_irq_en_i(ien),
        .reset_pin_select_i(sel), .shared_reset_pin_i(pin), .wdog_reset_i(rq[0]), .soft_reset_i(rq[1]),
        .break_reset_i(rq[2]), .idle_req_i(md[0]), .pd_req_i(md[1]), .tpd_req_i(md[2]), .irq_pending_i(irq),
        .wake_irq_i(wk), .rc_is_sysclk_i(rcs), .rtc_en_i(rtc), .comp_pd_i(cpd), .cause_wr_i(cw),
        .cause_wdata_i(wd), .boot_status0_i(bs), .isp_force_i(isp), .boot_vector_i(vec),
        .reset_cause_register_o(cause), .sys_reset_n_o(srn), .brownout_irq_o(birq), .flash_lockout_o(flk),
        .pin_data_o(pdat), .mode_o(mode), .main_osc_en_o(mosc), .rc_osc_en_o(rosc), .periph_clk_en_o(pclk),
        .keep_alive_en_o(kal), .comp_en_o(cen), .bod_en_o(ben), .fetch_addr_o(fa));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // inputs change 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // one-cycle reset request, then wait for release
    task automatic reset_req(input logic [2:0] r, input logic h, input logic [1:0] s);
        rq = r;
        hold = h;
        sup = s;
        step(1);
        rq = 3'h0;
        hold = 1'b0;
        sup = 2'h3;
        for (int i = 0; i < 20 && srn !== 1'b1; i++) step(1);
    endtask
    task automatic wr(input logic [5:0] m);
        cw = 1'b1;
        wd = m;
        step(1);
        cw = 1'b0;
        step(1);
    endtask
    task automatic go(input logic [2:0] m, input logic [1:0] exp);
        md = m;
        step(1);
        md = 3'h0;
        step(2);
        chk(mode, exp);
    endtask
    task automatic test_done;
        if (errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial begin
        step(2);
        rst_n = 1'b1;
        step(6);
        chk(cause, 6'h06);
        chk(fa, 16'h0000);
        wr(6'h3D);
        chk(cause, 6'h04);
        wr(6'h00);
        reset_req(3'h2, 1'b0, 2'h3);
        chk(cause, 6'h10);
        reset_req(3'h4, 1'b0, 2'h3);
        chk(cause, 6'h30);
        chk(fa, 16'hA500);
        wr(6'h20);
        reset_req(3'h0, 1'b1, 2'h3);
        chk({srn, cause}, 7'h60);
        hold = 1'b1;
        step(2);
        chk(pdat, 1'b0);
        hold = 1'b0;
        step(2);
        chk(pdat, 1'b1);
        sel = 1'b1;
        reset_req(3'h0, 1'b1, 2'h3);
        chk(fa, 16'h0000);
        chk(cause, 6'h21);
        bs = 1'b1;
        step(2);
        chk(fa, 16'hA500);
        bs = 1'b0;
        step(2);
        chk(fa, 16'h0000);
        reset_req(3'h1, 1'b0, 2'h3);
        chk(cause, 6'h06);
        wr(6'h00);
        reset_req(3'h0, 1'b0, 2'h0);
        chk(cause, 6'h04);
        sup = 2'h1;
        step(3);
        chk(birq, 1'b1);
        sup = 2'h2;
        step(3);
        chk(birq, 1'b0);
        sup = 2'h1;
        ien = 1'b0;
        step(3);
        chk(birq, 1'b0);
        fok = 1'b0;
        step(2);
        chk(flk, 1'b1);
        go(3'h2, 2'h2);
        chk({mosc, kal, cen, ben, rosc}, 5'h0E);
        chk(flk, 1'b0);
        cpd = 1'b1;
        step(2);
        chk(cen, 1'b0);
        cpd = 1'b0;
        fok = 1'b1;
        wk = 1'b1;
        step(3);
        wk = 1'b0;
        chk(mode, 2'h0);
        rtc = 1'b1;
        go(3'h4, 2'h3);
        chk({cen, ben, rosc}, 3'h1);
        rcs = 1'b0;
        step(2);
        chk(rosc, 1'b0);
        rcs = 1'b1;
        reset_req(3'h2, 1'b0, 2'h3);
        chk(mode, 2'h0);
        go(3'h1, 2'h1);
        chk(pclk, 1'b1);
        irq = 1'b1;
        step(3);
        irq = 1'b0;
        chk(mode, 2'h0);
        // frozen clock enable: idle request is not taken
        ce = 1'b0;
        go(3'h1, 2'h0);
        ce = 1'b1;
        // second power-on with the pin held low and forced programming
        sel = 1'b0;
        isp = 1'b1;
        hold = 1'b1;
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        step(6);
        chk(srn, 1'b0);
        chk(pdat, 1'b1);
        hold = 1'b0;
        step(6);
        chk(srn, 1'b1);
        chk(cause[1], 1'b1);
        chk(fa, 16'hA500);
        isp = 1'b0;
        test_done;
    end
    // hang guard
    initial begin
        #20000;
        errors++;
        test_done;
    end
endmodule // testbench
bind rps_supervisor rps_supervisor_asserts chk_u (.ref_clk_i, .reset_n_i, .wdog_reset_i, .soft_reset_i,
    .break_reset_i, .reset_pin_select_i, .shared_reset_pin_i, .irq_pending_i, .cause_wr_i, .cause_wdata_i,
    .supply_level_i, .brownout_reset_trip_hi_i, .brownout_reset_trip_lo_i,
    .reset_cause_register_o, .sys_reset_n_o, .mode_o, .main_osc_en_o, .comp_en_o, .bod_en_o, .fetch_addr_o);
